// ### arcic_pkg.sv
// constants, register map and field layout of the reference, calibration and route block
package arcic_pkg;

	// ********************************
	// widths
	// ********************************
	localparam int ARCIC_DATA_W = 24;
	localparam int ARCIC_NREG   = 8;
	localparam int ARCIC_IDX_W  = 6;
	localparam int ARCIC_SLOT_W = 3;
	localparam int ARCIC_BYTE_W = 8;

	// ********************************
	// register indices, byte address is four times the index
	// ********************************
	localparam logic [ARCIC_IDX_W-1:0] ARCIC_IDX_REF      = 6'h06;
	localparam logic [ARCIC_IDX_W-1:0] ARCIC_IDX_OFS_LO   = 6'h07;
	localparam logic [ARCIC_IDX_W-1:0] ARCIC_IDX_OFS_MID  = 6'h08;
	localparam logic [ARCIC_IDX_W-1:0] ARCIC_IDX_OFS_HI   = 6'h09;
	localparam logic [ARCIC_IDX_W-1:0] ARCIC_IDX_GAIN_LO  = 6'h0A;
	localparam logic [ARCIC_IDX_W-1:0] ARCIC_IDX_GAIN_MID = 6'h0B;
	localparam logic [ARCIC_IDX_W-1:0] ARCIC_IDX_GAIN_HI  = 6'h0C;
	localparam logic [ARCIC_IDX_W-1:0] ARCIC_IDX_CURRENT_SOURCE_ROUTING     = 6'h0D;

	// slot of each register in the local store (index minus first index)
	localparam int ARCIC_SLOT_REF      = 0;
	localparam int ARCIC_SLOT_OFS_LO   = 1;
	localparam int ARCIC_SLOT_OFS_MID  = 2;
	localparam int ARCIC_SLOT_OFS_HI   = 3;
	localparam int ARCIC_SLOT_GAIN_LO  = 4;
	localparam int ARCIC_SLOT_GAIN_MID = 5;
	localparam int ARCIC_SLOT_GAIN_HI  = 6;
	localparam int ARCIC_SLOT_CURRENT_SOURCE_ROUTING     = 7;

	// ********************************
	// reset values
	// ********************************
	localparam logic [7:0] ARCIC_REF_RST      = 8'h05;
	localparam logic [7:0] ARCIC_OFS_LO_RST   = 8'h00;
	localparam logic [7:0] ARCIC_OFS_MID_RST  = 8'h00;
	localparam logic [7:0] ARCIC_OFS_HI_RST   = 8'h00;
	localparam logic [7:0] ARCIC_GAIN_LO_RST  = 8'h00;
	localparam logic [7:0] ARCIC_GAIN_MID_RST = 8'h00;
	localparam logic [7:0] ARCIC_GAIN_HI_RST  = 8'h40;
	localparam logic [7:0] ARCIC_CURRENT_SOURCE_ROUTING_RST     = 8'hFF;
	localparam logic [ARCIC_NREG*ARCIC_BYTE_W-1:0] ARCIC_RST_ALL = {
		ARCIC_CURRENT_SOURCE_ROUTING_RST, ARCIC_GAIN_HI_RST, ARCIC_GAIN_MID_RST, ARCIC_GAIN_LO_RST,
		ARCIC_OFS_HI_RST, ARCIC_OFS_MID_RST, ARCIC_OFS_LO_RST, ARCIC_REF_RST};

	// ********************************
	// fields
	// ********************************
	localparam int ARCIC_ONCHIP_BIT = 4;
	localparam int ARCIC_POS_MSB    = 3;
	localparam int ARCIC_POS_LSB    = 2;
	localparam int ARCIC_NEG_MSB    = 1;
	localparam int ARCIC_NEG_LSB    = 0;
	localparam int ARCIC_R2_MSB     = 7;
	localparam int ARCIC_R2_LSB     = 4;
	localparam int ARCIC_R1_MSB     = 3;
	localparam int ARCIC_R1_LSB     = 0;

	// ********************************
	// datapath and routes
	// ********************************
	localparam int                      ARCIC_GAIN_SHIFT = 22;
	localparam logic [ARCIC_DATA_W-1:0] ARCIC_GAIN_UNITY = 24'h400000;
	localparam int                      ARCIC_ROUTE_N    = 11;
	localparam int                      ARCIC_ROUTE_COM  = 10;
	localparam int                      ARCIC_SMALL_AIN  = 5;
	localparam logic [ARCIC_ROUTE_N-1:0] ARCIC_ROUTE_NONE = 11'h000;
	localparam logic [3:0]              ARCIC_CODE_NC    = 4'hB;

	// ********************************
	// bus answers
	// ********************************
	localparam logic [1:0] ARCIC_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ARCIC_RESP_SLVERR = 2'h2;

endpackage

// ### arcic_route.sv
// decoder from a current source route code to one enable per analog pin
`timescale 1ns/1ps

module arcic_route
	import arcic_pkg::*;
#(
	parameter bit BIG_VARIANT = 1'b1
) (
	// route code
	input  wire logic [3:0]               code,
	// bit i closes the switch to analog input i, top bit to the common input
	output logic      [ARCIC_ROUTE_N-1:0] en
);

	// ********************************
	// decode
	// ********************************
	// codes at and above the common input's plus one leave every switch open
	for (genvar i = 0; i < ARCIC_ROUTE_N; i++) begin : g_sw
		localparam bit PRESENT = BIG_VARIANT || (i < ARCIC_SMALL_AIN) || (i == ARCIC_ROUTE_COM);
		assign en[i] = PRESENT && (code == 4'(i));
	end

endmodule

// ### arcic_corr.sv
// offset subtraction, gain scaling and clipping of conversion results
`timescale 1ns/1ps

module arcic_corr
	import arcic_pkg::*;
#(
	parameter int W = ARCIC_DATA_W
) (
	// clock and reset
	input  wire logic         core_clk,
	input  wire logic         rstn,
	// raw result
	input  wire logic [W-1:0] raw_data,
	input  wire logic         raw_valid,
	// correction words
	input  wire logic [W-1:0] offset_corr_word,
	input  wire logic [W-1:0] gain_corr_word,
	// corrected result
	output logic      [W-1:0] corr_data,
	output logic              corr_valid
);

	localparam int PW = 2 * (W + 1);
	localparam logic signed [PW-1:0] SAT_MAX = PW'((64'(1) <<< (W - 1)) - 64'(1));
	localparam logic signed [PW-1:0] SAT_MIN = -SAT_MAX - PW'(1);

	logic signed [W:0]    diff1;
	logic        [W-1:0]  gain1;
	logic                 valid1;
	logic signed [W:0]    diff_now;
	logic signed [PW-1:0] prod;
	logic signed [PW-1:0] scaled;

	// ********************************
	// stage 1: offset
	// ********************************
	// both sides signed, one bit wider so the difference never wraps
	assign diff_now = $signed({raw_data[W-1], raw_data}) -
		$signed({offset_corr_word[W-1], offset_corr_word});

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			diff1  <= '0;
			gain1  <= '0;
			valid1 <= 1'b0;
		end else begin
			diff1  <= diff_now;
			gain1  <= gain_corr_word;
			valid1 <= raw_valid;
		end
	end

	// ********************************
	// stage 2: gain and clip
	// ********************************
	// a zero top bit keeps the gain word unsigned
	assign prod   = PW'(diff1) * $signed({1'b0, gain1});
	assign scaled = prod >>> ARCIC_GAIN_SHIFT;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			corr_data  <= '0;
			corr_valid <= 1'b0;
		end else begin
			corr_valid <= valid1;
			if (scaled > SAT_MAX) begin
				corr_data <= SAT_MAX[W-1:0];
			end else if (scaled < SAT_MIN) begin
				corr_data <= SAT_MIN[W-1:0];
			end else begin
				corr_data <= scaled[W-1:0];
			end
		end
	end

	// ********************************
	// checks
	// ********************************
	logic diff_fits;
	assign diff_fits = (diff_now[W] == diff_now[W-1]);

	unity_pass_a: assert property (@(posedge core_clk) disable iff (!rstn)
		raw_valid && gain_corr_word == ARCIC_GAIN_UNITY && diff_fits
		|-> ##2 corr_valid && corr_data == $past(diff_now[W-1:0], 2))
		else $error("unity gain result is not raw minus offset");

	sign_keep_a: assert property (@(posedge core_clk) disable iff (!rstn)
		corr_valid && $past(gain1 != '0 && diff1 != '0)
		|-> corr_data[W-1] == $past(diff1[W]))
		else $error("corrected result wrapped to the wrong sign");

	gain_unsigned_a: assert property (@(posedge core_clk) disable iff (!rstn)
		corr_valid && $past(gain1[W-1] && diff1[W:W-1] == 2'h0 && diff1 != '0)
		|-> !corr_data[W-1] && $signed(corr_data) >= $past(diff1[W-1:0]))
		else $error("large gain word was not treated as unsigned");

endmodule

// ### arcic_cfg_top.sv
// reference select, calibration words and current routes behind an AXI4-Lite slave
`timescale 1ns/1ps

// How it works
// - bit 4 switches on-chip reference, reset off
// - bits 3:2 pick positive reference, reset 01
// - bits 1:0 pick negative reference, reset 01
// - offset word: three bytes, low byte first
// - offset word is signed two's complement
// - offset subtracted before gain scaling
// - gain word three bytes, resets to unity
// - gain word is unsigned straight binary
// - result multiplied by gain over 400000h
// - bits 7:4 route second current source
// - bits 3:0 route first current source
module arcic_cfg_top
	import arcic_pkg::*;
#(
	parameter int AXI_AW      = 8,
	parameter bit BIG_VARIANT = 1'b1
) (
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     rstn,
	// axi4-lite write address
	input  wire logic [AXI_AW-1:0]        s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	// axi4-lite write response
	output logic      [1:0]               s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// axi4-lite read address
	input  wire logic [AXI_AW-1:0]        s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	// axi4-lite read data
	output logic      [31:0]              s_axi_rdata,
	output logic      [1:0]               s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// conversion results
	input  wire logic [ARCIC_DATA_W-1:0]  raw_data,
	input  wire logic                     raw_valid,
	output logic      [ARCIC_DATA_W-1:0]  corr_data,
	output logic                          corr_valid,
	// reference control
	output logic                          onchip_vsrc_on,
	output logic      [1:0]               pos_vsrc_select,
	output logic      [1:0]               neg_vsrc_select,
	// current source switches
	output logic      [ARCIC_ROUTE_N-1:0] first_current_route,
	output logic      [ARCIC_ROUTE_N-1:0] second_current_route
);

	// ********************************
	// declarations
	// ********************************
	logic                               aw_held;
	logic                               w_held;
	logic [AXI_AW-1:0]                  aw_addr;
	logic [31:0]                        w_data;
	logic [3:0]                         w_strb;
	logic                               next_aw_held;
	logic                               next_w_held;
	logic                               next_bvalid;
	logic                               next_rvalid;
	logic                               do_write;
	logic [ARCIC_IDX_W-1:0]             wr_idx;
	logic [ARCIC_IDX_W-1:0]             rd_idx;
	logic [ARCIC_IDX_W-1:0]             wr_off;
	logic [ARCIC_IDX_W-1:0]             rd_off;
	logic                               wr_mapped;
	logic                               rd_mapped;
	logic [ARCIC_NREG*ARCIC_BYTE_W-1:0] cfg_all;
	logic [7:0]                         ref_byte;
	logic [7:0]                         current_source_routing_byte;
	logic [7:0]                         rd_byte;
	logic [ARCIC_DATA_W-1:0]            offset_corr_word;
	logic [ARCIC_DATA_W-1:0]            gain_corr_word;
	logic [3:0]                         first_current_code;
	logic [3:0]                         second_current_code;
	logic [ARCIC_ROUTE_N-1:0]           first_en;
	logic [ARCIC_ROUTE_N-1:0]           second_en;

	// ********************************
	// address decode
	// ********************************
	// only the word index counts, the two low address bits are ignored
	assign wr_idx    = ARCIC_IDX_W'(aw_addr[AXI_AW-1:2]);
	assign rd_idx    = ARCIC_IDX_W'(s_axi_araddr[AXI_AW-1:2]);
	assign wr_off    = wr_idx - ARCIC_IDX_REF;
	assign rd_off    = rd_idx - ARCIC_IDX_REF;
	assign wr_mapped = (wr_idx >= ARCIC_IDX_REF) && (wr_idx <= ARCIC_IDX_CURRENT_SOURCE_ROUTING);
	assign rd_mapped = (rd_idx >= ARCIC_IDX_REF) && (rd_idx <= ARCIC_IDX_CURRENT_SOURCE_ROUTING);

	// ********************************
	// write channels
	// ********************************
	// address and data are caught independently; the write fires once both are held
	assign do_write     = aw_held && w_held && !s_axi_bvalid;
	assign next_aw_held = do_write ? 1'b0 : (aw_held || (s_axi_awvalid && s_axi_awready));
	assign next_w_held  = do_write ? 1'b0 : (w_held || (s_axi_wvalid && s_axi_wready));
	assign next_bvalid  = do_write ? 1'b1 : (s_axi_bvalid && !s_axi_bready);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			aw_held <= 1'b0;
			aw_addr <= '0;
			s_axi_awready <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
			end
			s_axi_awready <= !next_aw_held && !next_bvalid;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
			s_axi_wready <= 1'b0;
		end else begin
			w_held <= next_w_held;
			if (s_axi_wvalid && s_axi_wready) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			s_axi_wready <= !next_w_held && !next_bvalid;
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ARCIC_RESP_OKAY;
		end else begin
			s_axi_bvalid <= next_bvalid;
			if (do_write) begin
				s_axi_bresp <= wr_mapped ? ARCIC_RESP_OKAY : ARCIC_RESP_SLVERR;
			end
		end
	end

	// ********************************
	// register store
	// ********************************
	// every byte is kept whole, reserved bits included, so a read returns what was written
	for (genvar g = 0; g < ARCIC_NREG; g++) begin : g_reg
		logic [7:0] byte_q;
		always_ff @(posedge core_clk or negedge rstn) begin
			if (!rstn) begin
				byte_q <= ARCIC_RST_ALL[g*ARCIC_BYTE_W +: ARCIC_BYTE_W];
			end else if (do_write && wr_mapped && w_strb[0] &&
				wr_off[ARCIC_SLOT_W-1:0] == ARCIC_SLOT_W'(g)) begin
				byte_q <= w_data[ARCIC_BYTE_W-1:0];
			end
		end
		assign cfg_all[g*ARCIC_BYTE_W +: ARCIC_BYTE_W] = byte_q;
	end

	assign ref_byte  = cfg_all[ARCIC_SLOT_REF*ARCIC_BYTE_W +: ARCIC_BYTE_W];
	assign current_source_routing_byte = cfg_all[ARCIC_SLOT_CURRENT_SOURCE_ROUTING*ARCIC_BYTE_W +: ARCIC_BYTE_W];
	assign offset_corr_word = {cfg_all[ARCIC_SLOT_OFS_HI*ARCIC_BYTE_W +: ARCIC_BYTE_W],
		cfg_all[ARCIC_SLOT_OFS_MID*ARCIC_BYTE_W +: ARCIC_BYTE_W],
		cfg_all[ARCIC_SLOT_OFS_LO*ARCIC_BYTE_W +: ARCIC_BYTE_W]};
	assign gain_corr_word = {cfg_all[ARCIC_SLOT_GAIN_HI*ARCIC_BYTE_W +: ARCIC_BYTE_W],
		cfg_all[ARCIC_SLOT_GAIN_MID*ARCIC_BYTE_W +: ARCIC_BYTE_W],
		cfg_all[ARCIC_SLOT_GAIN_LO*ARCIC_BYTE_W +: ARCIC_BYTE_W]};

	// ********************************
	// read channel
	// ********************************
	assign rd_byte     = rd_mapped ? cfg_all[rd_off[ARCIC_SLOT_W-1:0]*ARCIC_BYTE_W +:
		ARCIC_BYTE_W] : 8'h00;
	assign next_rvalid = (s_axi_arvalid && s_axi_arready) || (s_axi_rvalid && !s_axi_rready);

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= ARCIC_RESP_OKAY;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_rvalid  <= next_rvalid;
			s_axi_arready <= !next_rvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_mapped ? ARCIC_RESP_OKAY : ARCIC_RESP_SLVERR;
			end
		end
	end

	// ********************************
	// reference and route outputs
	// ********************************
	assign first_current_code  = current_source_routing_byte[ARCIC_R1_MSB:ARCIC_R1_LSB];
	assign second_current_code = current_source_routing_byte[ARCIC_R2_MSB:ARCIC_R2_LSB];

	arcic_route #(
		.BIG_VARIANT (BIG_VARIANT)
	) u_first_route (
		.code (first_current_code),
		.en   (first_en)
	);

	arcic_route #(
		.BIG_VARIANT (BIG_VARIANT)
	) u_second_route (
		.code (second_current_code),
		.en   (second_en)
	);

	// outputs lag the store by one clock so that every pin comes from a flop
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			onchip_vsrc_on       <= ARCIC_REF_RST[ARCIC_ONCHIP_BIT];
			pos_vsrc_select      <= ARCIC_REF_RST[ARCIC_POS_MSB:ARCIC_POS_LSB];
			neg_vsrc_select      <= ARCIC_REF_RST[ARCIC_NEG_MSB:ARCIC_NEG_LSB];
			first_current_route  <= ARCIC_ROUTE_NONE;
			second_current_route <= ARCIC_ROUTE_NONE;
		end else begin
			onchip_vsrc_on       <= ref_byte[ARCIC_ONCHIP_BIT];
			pos_vsrc_select      <= ref_byte[ARCIC_POS_MSB:ARCIC_POS_LSB];
			neg_vsrc_select      <= ref_byte[ARCIC_NEG_MSB:ARCIC_NEG_LSB];
			first_current_route  <= first_en;
			second_current_route <= second_en;
		end
	end

	// ********************************
	// correction datapath
	// ********************************
	arcic_corr #(
		.W (ARCIC_DATA_W)
	) u_corr (
		.core_clk         (core_clk),
		.rstn             (rstn),
		.raw_data         (raw_data),
		.raw_valid        (raw_valid),
		.offset_corr_word (offset_corr_word),
		.gain_corr_word   (gain_corr_word),
		.corr_data        (corr_data),
		.corr_valid       (corr_valid)
	);

	// ********************************
	// checks
	// ********************************
	sequence ref_write_s;
		do_write && wr_idx == ARCIC_IDX_REF && w_strb[0];
	endsequence

	sequence current_source_routing_write_s;
		do_write && wr_idx == ARCIC_IDX_CURRENT_SOURCE_ROUTING && w_strb[0];
	endsequence

	reset_vals_a: assert property (@(posedge core_clk) disable iff (!rstn)
		$rose(rstn) |-> !onchip_vsrc_on && pos_vsrc_select == 2'h1 &&
			neg_vsrc_select == 2'h1 && gain_corr_word == ARCIC_GAIN_UNITY)
		else $error("reference outputs or gain word wrong after reset");

	ref_on_a: assert property (@(posedge core_clk) disable iff (!rstn)
		ref_write_s |-> ##2 onchip_vsrc_on == $past(w_data[ARCIC_ONCHIP_BIT], 2))
		else $error("on-chip reference did not follow its bit");

	pos_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
		ref_write_s |-> ##2 pos_vsrc_select == $past(w_data[ARCIC_POS_MSB:ARCIC_POS_LSB], 2))
		else $error("positive reference select did not follow its field");

	neg_sel_a: assert property (@(posedge core_clk) disable iff (!rstn)
		ref_write_s |-> ##2 neg_vsrc_select == $past(w_data[ARCIC_NEG_MSB:ARCIC_NEG_LSB], 2))
		else $error("negative reference select did not follow its field");

	ofs_byte_a: assert property (@(posedge core_clk) disable iff (!rstn)
		do_write && wr_idx == ARCIC_IDX_OFS_HI && w_strb[0]
		|=> offset_corr_word[ARCIC_DATA_W-1:2*ARCIC_BYTE_W] == $past(w_data[7:0]))
		else $error("offset high byte not in the top bits of the word");

	gain_byte_a: assert property (@(posedge core_clk) disable iff (!rstn)
		do_write && wr_idx == ARCIC_IDX_GAIN_LO && w_strb[0]
		|=> gain_corr_word[ARCIC_BYTE_W-1:0] == $past(w_data[7:0]))
		else $error("gain low byte not in the low bits of the word");

	route2_nc_a: assert property (@(posedge core_clk) disable iff (!rstn)
		current_source_routing_write_s ##0 w_data[ARCIC_R2_MSB:ARCIC_R2_LSB] >= ARCIC_CODE_NC
		|-> ##2 second_current_route == ARCIC_ROUTE_NONE)
		else $error("second current source connected on a no-connect code");

	route1_com_a: assert property (@(posedge core_clk) disable iff (!rstn)
		current_source_routing_write_s ##0 w_data[ARCIC_R1_MSB:ARCIC_R1_LSB] == 4'(ARCIC_ROUTE_COM)
		|-> ##2 first_current_route == (ARCIC_ROUTE_N'(1) << ARCIC_ROUTE_COM))
		else $error("first current source not on the common input");

	rd_answer_a: assert property (@(posedge core_clk) disable iff (!rstn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not one cycle after the address");

endmodule

// ### arcic_placeholder_end.sv
// intentionally empty
`timescale 1ns/1ps

// ### tb_adc_ref_cal_idac_config.sv
// self-checking testbench of the reference, calibration and current route block
`timescale 1ns/1ps

module tb_adc_ref_cal_idac_config;
	import arcic_pkg::*;

	typedef struct {
		logic [23:0] ofs;
		logic [23:0] gain;
		logic [23:0] raw;
		logic [23:0] res;
	} arcic_tbrow_t;

	logic        core_clk = 1'b0;
	logic        rstn     = 1'b0;
	logic [7:0]  awaddr   = 8'h00;
	logic        awvalid  = 1'b0;
	logic        awready;
	logic [31:0] wdata    = 32'h0;
	logic [3:0]  wstrb    = 4'h0;
	logic        wvalid   = 1'b0;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready   = 1'b0;
	logic [7:0]  araddr   = 8'h00;
	logic        arvalid  = 1'b0;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready   = 1'b0;
	logic [23:0] raw_data = 24'h0;
	logic        raw_valid = 1'b0;
	logic [23:0] corr_data;
	logic        corr_valid;
	logic        onchip;
	logic [1:0]  pos_sel;
	logic [1:0]  neg_sel;
	logic [10:0] route1;
	logic [10:0] route2;
	int          n_fail = 0;
	int          checks = 0;
	logic [7:0]  v;

	// gain C00000 tells offset-first from gain-first; 800000 and FFFFFF need unsigned gain
	arcic_tbrow_t rows [7] = '{
		'{24'h000000, 24'h400000, 24'h123456, 24'h123456},
		'{24'h000010, 24'h400000, 24'h000005, 24'hFFFFF5},
		'{24'hFFFFF0, 24'h800000, 24'h000010, 24'h000040},
		'{24'h000000, 24'hFFFFFF, 24'h7FFFFF, 24'h7FFFFF},
		'{24'h7FFFFF, 24'h400000, 24'h800000, 24'h800000},
		'{24'h000000, 24'h200000, 24'hFFFFFF, 24'hFFFFFF},
		'{24'h000100, 24'hC00000, 24'h000300, 24'h000600}};

	arcic_cfg_top i_dut (
		.core_clk            (core_clk),
		.rstn                (rstn),
		.s_axi_awaddr        (awaddr),
		.s_axi_awvalid       (awvalid),
		.s_axi_awready       (awready),
		.s_axi_wdata         (wdata),
		.s_axi_wstrb         (wstrb),
		.s_axi_wvalid        (wvalid),
		.s_axi_wready        (wready),
		.s_axi_bresp         (bresp),
		.s_axi_bvalid        (bvalid),
		.s_axi_bready        (bready),
		.s_axi_araddr        (araddr),
		.s_axi_arvalid       (arvalid),
		.s_axi_arready       (arready),
		.s_axi_rdata         (rdata),
		.s_axi_rresp         (rresp),
		.s_axi_rvalid        (rvalid),
		.s_axi_rready        (rready),
		.raw_data            (raw_data),
		.raw_valid           (raw_valid),
		.corr_data           (corr_data),
		.corr_valid          (corr_valid),
		.onchip_vsrc_on      (onchip),
		.pos_vsrc_select     (pos_sel),
		.neg_vsrc_select     (neg_sel),
		.first_current_route (route1),
		.second_current_route(route2)
	);

	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	// ********************************
	// helpers
	// ********************************
	task finish_test();
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task give_up();
		n_fail++;
		finish_test();
	endtask

	// address and data offered together, each released once taken
	task wr(input logic [5:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [1:0] er);
		int n;
		@(posedge core_clk);
		awaddr  <= {idx, 2'b00};
		wdata   <= {24'h0, d};
		wstrb   <= st;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		if (n == 50)
			give_up();
		bready <= 1'b0;
		chk("bresp", bresp, er);
	endtask

	task rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge core_clk);
		araddr  <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge core_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		if (n == 50)
			give_up();
		rready <= 1'b0;
		chk("rdata", rdata, {24'h0, d});
		chk("rresp", rresp, er);
	endtask

	// result must appear exactly one edge after the sampling edge, for one cycle
	task conv(input logic [23:0] r, input logic [23:0] e);
		@(posedge core_clk);
		raw_data  <= r;
		raw_valid <= 1'b1;
		@(posedge core_clk);
		raw_valid <= 1'b0;
		raw_data  <= ~r;
		@(posedge core_clk);
		#1;
		chk("corr_valid", corr_valid, 1);
		chk("corr_data", corr_data, e);
		@(posedge core_clk);
		#1;
		chk("corr_valid low", corr_valid, 0);
	endtask

	function automatic logic [10:0] route_exp(input logic [3:0] c);
		return (c <= 4'hA) ? 11'h001 << c : 11'h000;
	endfunction

	// ********************************
	// main sequence
	// ********************************
	initial begin
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		chk("onchip rst", onchip, 0);
		chk("pos rst", pos_sel, 2'h1);
		chk("neg rst", neg_sel, 2'h1);
		chk("routes rst", {route2, route1}, 22'h0);
		for (int i = 0; i < 8; i++)
			rd(ARCIC_IDX_REF + 6'(i), ARCIC_RST_ALL[i*8 +: 8], ARCIC_RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			wr(ARCIC_IDX_OFS_LO, rows[i].ofs[7:0], 4'h1, ARCIC_RESP_OKAY);
			wr(ARCIC_IDX_OFS_MID, rows[i].ofs[15:8], 4'h1, ARCIC_RESP_OKAY);
			wr(ARCIC_IDX_OFS_HI, rows[i].ofs[23:16], 4'h1, ARCIC_RESP_OKAY);
			wr(ARCIC_IDX_GAIN_LO, rows[i].gain[7:0], 4'h1, ARCIC_RESP_OKAY);
			wr(ARCIC_IDX_GAIN_MID, rows[i].gain[15:8], 4'h1, ARCIC_RESP_OKAY);
			wr(ARCIC_IDX_GAIN_HI, rows[i].gain[23:16], 4'h1, ARCIC_RESP_OKAY);
			conv(rows[i].raw, rows[i].res);
		end
		// two samples on consecutive cycles
		@(posedge core_clk);
		raw_data  <= 24'h000300;
		raw_valid <= 1'b1;
		@(posedge core_clk);
		raw_data  <= 24'h000500;
		@(posedge core_clk);
		raw_valid <= 1'b0;
		#1;
		chk("b2b first", {corr_valid, corr_data}, {1'b1, 24'h000600});
		@(posedge core_clk);
		#1;
		chk("b2b second", {corr_valid, corr_data}, {1'b1, 24'h000C00});
		for (int k = 0; k < 4; k++) begin
			v = (k == 0) ? 8'hF6 : (k == 1) ? 8'h09 : (k == 2) ? 8'h10 : 8'h0F;
			wr(ARCIC_IDX_REF, v, 4'h1, ARCIC_RESP_OKAY);
			rd(ARCIC_IDX_REF, v, ARCIC_RESP_OKAY);
			chk("ref fields", {onchip, pos_sel, neg_sel}, v[4:0]);
		end
		wr(ARCIC_IDX_REF, 8'hAA, 4'h0, ARCIC_RESP_OKAY);
		rd(ARCIC_IDX_REF, 8'h0F, ARCIC_RESP_OKAY);
		for (int c = 0; c < 16; c++) begin
			wr(ARCIC_IDX_CURRENT_SOURCE_ROUTING, {4'(c), 4'(15 - c)}, 4'h1, ARCIC_RESP_OKAY);
			// route pins follow the store one edge later, at the edge the response is taken
			#1;
			chk("route2", route2, route_exp(4'(c)));
			chk("route1", route1, route_exp(4'(15 - c)));
		end
		wr(6'h00, 8'h55, 4'h1, ARCIC_RESP_SLVERR);
		rd(6'h05, 8'h00, ARCIC_RESP_SLVERR);
		rd(6'h0E, 8'h00, ARCIC_RESP_SLVERR);
		// reset again in mid-run with non-default contents
		@(posedge core_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		chk("pos rst2", {onchip, pos_sel, neg_sel, route2, route1}, {5'h05, 22'h0});
		@(posedge core_clk);
		rstn <= 1'b1;
		rd(ARCIC_IDX_REF, ARCIC_REF_RST, ARCIC_RESP_OKAY);
		rd(ARCIC_IDX_GAIN_HI, ARCIC_GAIN_HI_RST, ARCIC_RESP_OKAY);
		rd(ARCIC_IDX_CURRENT_SOURCE_ROUTING, ARCIC_CURRENT_SOURCE_ROUTING_RST, ARCIC_RESP_OKAY);
		finish_test();
	end
endmodule
